// ===== rtl/lfc_pkg.sv
// Constants and carrier types for the link feature control register
package lfc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] LFC_OFFSET = 8'hF4;
    localparam logic [31:0] LFC_RESET = 32'h0000_1000;
    // Writable bits: 15, 13, 12, 10, 8, 7, 1
    localparam logic [31:0] LFC_WR_MASK = 32'h0000_B582;
    localparam logic [31:0] LFC_ZERO = 32'h0000_0000;
    localparam int LFC_NO_OOO_BIT = 15;
    localparam int LFC_HC_GATE_BIT = 22;
    localparam int LFC_EEP_WIDTH = 16;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } lfc_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } lfc_cfg_rsp_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } lfc_eep_t;
endpackage

// ===== rtl/lfc_eeprom_load.sv
// Start-up load path from the serial EEPROM loader into the register
`timescale 1ns/1ns
module lfc_eeprom_load (
    input wire logic clk,
    input wire logic resetn,
    input wire logic eeprom_present,
    input wire lfc_pkg::lfc_eep_t eep_word,
    output lfc_pkg::lfc_eep_t eep_load
);
    import lfc_pkg::*;

    // ------------------------------------------------------------
    // Registered load strobe
    // ------------------------------------------------------------
    // Without a device attached the loader lines are not trusted
    always_ff @(posedge clk) begin
        if (!resetn) begin
            eep_load <= '0;
        end else begin
            eep_load.valid <= eep_word.valid & eeprom_present;
            eep_load.word <= eep_word.word;
        end
    end
endmodule

// ===== rtl/lfc_link_feature_control.sv
// Link feature control register with its gated enhancement outputs
// ------------------------------------------------------------
// How it works
// - An enhancement bit acts only while the enhancement gate is also one.
// - Bits 31 to 16 always read as zero.
// - Bit 15 set stops out-of-order transmit pipelining, so requests go strictly in sequence.
// - Writable bits load from software writes or from an attached serial EEPROM.
// - Only the global reset input returns the bits to their defaults.
// ------------------------------------------------------------
`timescale 1ns/1ns
module lfc_link_feature_control (
    input wire logic clk,
    input wire logic resetn,
    input wire lfc_pkg::lfc_cfg_req_t cfg_req,
    output lfc_pkg::lfc_cfg_rsp_t cfg_rsp,
    input wire logic enhancement_gate,
    input wire logic eeprom_present,
    input wire lfc_pkg::lfc_eep_t eep_word,
    output logic [15:0] enh_active,
    output logic no_out_of_order_tx_pipelining,
    output logic tx_pipeline_allow
);
    import lfc_pkg::*;

    logic [31:0] lfc_reg;
    logic [31:0] lfc_next;
    logic [31:0] be_mask;
    logic hit;
    lfc_eep_t eep_load;

    // ------------------------------------------------------------
    // EEPROM load path
    // ------------------------------------------------------------
    lfc_eeprom_load u_eep (
        .clk(clk),
        .resetn(resetn),
        .eeprom_present(eeprom_present),
        .eep_word(eep_word),
        .eep_load(eep_load)
    );

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    assign hit = (cfg_req.addr[7:2] == LFC_OFFSET[7:2]);

    always_comb begin
        be_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
        lfc_next = lfc_reg;
        if (eep_load.valid) begin
            lfc_next = (lfc_reg & ~LFC_WR_MASK) | ({16'h0000, eep_load.word} & LFC_WR_MASK);
        end
        // Software write lands after the EEPROM so a late host write is not undone
        // masked write
        if (cfg_req.wr && hit) begin
            lfc_next = (lfc_next & ~(LFC_WR_MASK & be_mask)) | (cfg_req.wdata & LFC_WR_MASK & be_mask);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lfc_reg <= LFC_RESET;
        end else begin
            lfc_reg <= lfc_next;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp.ack <= cfg_req.rd | cfg_req.wr;
            if (cfg_req.rd && hit) begin
                cfg_rsp.rdata <= lfc_reg & LFC_WR_MASK;
            end else begin
                cfg_rsp.rdata <= LFC_ZERO;
            end
        end
    end

    // ------------------------------------------------------------
    // Gated enhancement outputs
    // ------------------------------------------------------------
    // Gate is a register bit on the same clock, so no synchroniser
    always_ff @(posedge clk) begin
        if (!resetn) begin
            enh_active <= 16'h0000;
            no_out_of_order_tx_pipelining <= 1'b0;
        end else begin
            enh_active <= lfc_reg[15:0] & LFC_WR_MASK[15:0] & {16{enhancement_gate}};
            no_out_of_order_tx_pipelining <= lfc_reg[LFC_NO_OOO_BIT] & enhancement_gate;
        end
    end

    // ------------------------------------------------------------
    // Transmit pipeline permission
    // ------------------------------------------------------------
    // Own flop keeps the permission a clean level for the transmit side
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_pipeline_allow <= 1'b1;
        end else begin
            tx_pipeline_allow <= ~(lfc_reg[LFC_NO_OOO_BIT] & enhancement_gate);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_gate_off;
        @(posedge clk) disable iff (!resetn)
        !enhancement_gate |=> (enh_active == 16'h0000) && !no_out_of_order_tx_pipelining;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("enhancement active with gate low");

    property p_upper_zero;
        @(posedge clk) disable iff (!resetn)
        cfg_rsp.ack |-> cfg_rsp.rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved upper half read nonzero");

    property p_in_order;
        @(posedge clk) disable iff (!resetn)
        (cfg_req.wr && hit && cfg_req.be[1] && cfg_req.wdata[15]) ##1 enhancement_gate [*2]
        |-> no_out_of_order_tx_pipelining && !tx_pipeline_allow;
    endproperty
    a_in_order: assert property (p_in_order) else $error("pipelining not disabled by bit 15");

    property p_eep_load;
        @(posedge clk) disable iff (!resetn)
        (eep_word.valid && eeprom_present) ##1 !(cfg_req.wr && hit)
        |=> lfc_reg[15:0] == ($past(eep_word.word, 2) & LFC_WR_MASK[15:0]);
    endproperty
    a_eep_load: assert property (p_eep_load) else $error("EEPROM word not loaded");

    property p_reset_value;
        @(posedge clk) !resetn |=> lfc_reg == LFC_RESET && enh_active == 16'h0000;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset did not restore default");

    property p_ro_hold;
        @(posedge clk) disable iff (!resetn)
        ##1 (lfc_reg & ~LFC_WR_MASK) == LFC_ZERO;
    endproperty
    a_ro_hold: assert property (p_ro_hold) else $error("read-only bit took a value");

    property p_rd_value;
        @(posedge clk) disable iff (!resetn)
        (cfg_req.rd && hit) |=> cfg_rsp.ack && cfg_rsp.rdata == ($past(lfc_reg) & LFC_WR_MASK);
    endproperty
    a_rd_value: assert property (p_rd_value) else $error("read data does not match register");

    // ------------------------------------------------------------
    // Checks on the bus answer and the hold of the bits
    // ------------------------------------------------------------
    property p_miss_zero;
        @(posedge clk) disable iff (!resetn)
        (cfg_req.rd || cfg_req.wr) && !(cfg_req.rd && hit) |=> cfg_rsp.ack && cfg_rsp.rdata == LFC_ZERO;
    endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("write or unmapped read returned data");

    property p_no_ack;
        @(posedge clk) disable iff (!resetn)
        !(cfg_req.rd || cfg_req.wr) |=> !cfg_rsp.ack;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("answer without a request");

    property p_wr_lands;
        @(posedge clk) disable iff (!resetn)
        (cfg_req.wr && hit && cfg_req.be[1]) |=> lfc_reg[LFC_NO_OOO_BIT] == $past(cfg_req.wdata[LFC_NO_OOO_BIT]);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("software write to bit 15 did not land");

    property p_hold;
        @(posedge clk) disable iff (!resetn)
        !(cfg_req.wr && hit) && !eep_load.valid |=> $stable(lfc_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("register moved without a write or load");

    property p_reset_outputs;
        @(posedge clk) !resetn |=> !cfg_rsp.ack && cfg_rsp.rdata == LFC_ZERO
            && !no_out_of_order_tx_pipelining && tx_pipeline_allow;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not at reset level");

    // ------------------------------------------------------------
    // Checks on the gated outputs and the load path
    // ------------------------------------------------------------
    property p_gate_on;
        @(posedge clk) disable iff (!resetn)
        enhancement_gate |=> enh_active == ($past(lfc_reg[15:0]) & LFC_WR_MASK[15:0]);
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("enhancement bits not passed with gate high");

    property p_follow;
        @(posedge clk) disable iff (!resetn)
        lfc_reg[LFC_NO_OOO_BIT] && enhancement_gate |=> no_out_of_order_tx_pipelining;
    endproperty
    a_follow: assert property (p_follow) else $error("in-order transmit not requested");

    property p_allow_inverse;
        @(posedge clk) disable iff (!resetn)
        tx_pipeline_allow != no_out_of_order_tx_pipelining;
    endproperty
    a_allow_inverse: assert property (p_allow_inverse) else $error("pipeline permission disagrees");

    property p_eep_absent;
        @(posedge clk) disable iff (!resetn)
        eep_word.valid && !eeprom_present |=> !eep_load.valid;
    endproperty
    a_eep_absent: assert property (p_eep_absent) else $error("load taken without an EEPROM");

    c_sw_write: cover property (@(posedge clk) disable iff (!resetn) cfg_req.wr && hit ##1 cfg_rsp.ack);
    c_eep: cover property (@(posedge clk) disable iff (!resetn) eep_load.valid);
    c_in_order: cover property (@(posedge clk) disable iff (!resetn) no_out_of_order_tx_pipelining);
    c_read: cover property (@(posedge clk) disable iff (!resetn) cfg_req.rd && hit ##1 cfg_rsp.rdata != LFC_ZERO);
    c_gate_block: cover property (@(posedge clk) disable iff (!resetn) !enhancement_gate && lfc_reg[LFC_NO_OOO_BIT]);
endmodule

// ===== testbench/lfc_host_model.sv
// Host configuration access model for the register bus
`timescale 1ns/1ns
module lfc_host_model import lfc_pkg::*; (
    input wire logic clk,
    output lfc_pkg::lfc_cfg_req_t cfg_req
);
    initial cfg_req = '0;
    task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
        @(negedge clk);
        cfg_req = '{rd: rd, wr: wr, addr: a, be: be, wdata: d};
    endtask
    // Released data is inverted so a stale value never looks valid
    task automatic idle();
        @(negedge clk);
        cfg_req.rd = 1'b0;
        cfg_req.wr = 1'b0;
        cfg_req.wdata = ~cfg_req.wdata;
    endtask
endmodule

// ===== testbench/lfc_link_feature_control_tb_top.sv
// Self-checking bench for the link feature control register
`timescale 1ns/1ns
module lfc_link_feature_control_tb_top;
    import lfc_pkg::*;
    logic clk = 1'b0, resetn, gate, present;
    lfc_eep_t eep;
    lfc_cfg_req_t req;
    lfc_cfg_rsp_t rsp;
    logic [15:0] enh;
    logic no_ooo, allow;
    logic [31:0] m, exp_q[$];
    int miscompares = 0, comparisons = 0, seed, i;
    always #5 clk = ~clk;
    lfc_host_model host (.clk(clk), .cfg_req(req));
    lfc_link_feature_control dut (.clk(clk), .resetn(resetn), .cfg_req(req), .cfg_rsp(rsp),
        .enhancement_gate(gate), .eeprom_present(present), .eep_word(eep), .enh_active(enh),
        .no_out_of_order_tx_pipelining(no_ooo), .tx_pipeline_allow(allow));
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (rsp.ack === 1'b1) check("rdata", rsp.rdata, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & LFC_WR_MASK;
        host.access(1'b0, 1'b1, a, be, d);
        if (a[7:2] == LFC_OFFSET[7:2]) m = (m & ~bm) | (d & bm);
        exp_q.push_back(LFC_ZERO);
    endtask
    task automatic rd(input logic [7:0] a);
        host.access(1'b1, 1'b0, a, 4'hF, $random(seed));
        exp_q.push_back(a[7:2] == LFC_OFFSET[7:2] ? m : LFC_ZERO);
    endtask
    task automatic check_outs();
        host.idle();
        repeat (3) @(negedge clk);
        check("enh_active", {16'h0000, enh}, {16'h0000, m[15:0] & {16{gate}}});
        check("no_ooo", {31'h0, no_ooo}, {31'h0, m[15] & gate});
        check("allow", {31'h0, allow}, {31'h0, ~(m[15] & gate)});
    endtask
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h5455;
        resetn = 1'b0;
        gate = 1'b0;
        present = 1'b0;
        eep = '0;
        m = LFC_RESET;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(LFC_OFFSET);
        wr(LFC_OFFSET, 4'hF, 32'hFFFF_FFFF);
        rd(LFC_OFFSET);
        check_outs();
        gate = 1'b1;
        check_outs();
        for (i = 0; i < 24; i++) begin
            wr(($random(seed) & 3) ? LFC_OFFSET : 8'hF0, 4'($random(seed)), $random(seed));
            rd(($random(seed) & 3) ? LFC_OFFSET : 8'hF8);
            gate = 1'($random(seed));
            check_outs();
        end
        for (i = 0; i < 2; i++) begin
            present = i[0];
            @(negedge clk);
            eep = '{valid: 1'b1, word: 16'($random(seed))};
            if (present) m[15:0] = (m[15:0] & ~LFC_WR_MASK[15:0]) | (eep.word & LFC_WR_MASK[15:0]);
            @(negedge clk);
            eep.valid = 1'b0;
            repeat (2) @(negedge clk);
            rd(LFC_OFFSET);
            check_outs();
        end
        @(negedge clk);
        resetn = 1'b0;
        m = LFC_RESET;
        @(negedge clk);
        resetn = 1'b1;
        rd(LFC_OFFSET);
        check_outs();
        check("queue", exp_q.size(), 0);
        give_verdict();
    end
endmodule
